// ==== dv/pmm_host_model.sv ====
// Two-wire bus master model driving the monitor's serial pins
module pmm_host_model
    import pmm_pkg::*;
(
    output logic     scl_o,
    output logic     pull_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    task automatic bit_x(input logic b, output logic r);
        pull_o = !b;
        #31.25 scl_o = 1'b1;
        #31.25 r = sda_i;
        #31.25 scl_o = 1'b0;
        #31.25;
    endtask : bit_x
    // Start when first=0, stop when first=1
    task automatic cond(input logic first, input logic last);
        pull_o = first;
        #31.25 scl_o = 1'b1;
        #31.25 pull_o = last;
        #31.25 scl_o = !last;
        #31.25;
    endtask : cond
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(1'b1, r);
        a = !r;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k1, k2, k3;
        cond(1'b0, 1'b1);
        xfer({PMM_DEV_ADDR, 1'b0}, q, k1);
        xfer(a, q, k2);
        xfer(d, q, k3);
        cond(1'b1, 1'b0);
        ok = k1 & k2 & k3;
    endtask : wr
    // Random read, single byte, ends with nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k1, k2, k3, n;
        cond(1'b0, 1'b1);
        xfer({PMM_DEV_ADDR, 1'b0}, d, k1);
        xfer(a, d, k2);
        cond(1'b0, 1'b1);
        xfer({PMM_DEV_ADDR, 1'b1}, d, k3);
        xfer(8'hff, d, n);
        cond(1'b1, 1'b0);
        ok = k1 & k2 & k3 & !n;
    endtask : rd
endmodule : pmm_host_model

// ==== dv/pmm_memory_map_properties.sv ====
// Bus-side properties of the paged monitor memory map
module pmm_memory_map_properties
    import pmm_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic        scl_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic [7:0]  page_select_o,
    input wire logic [31:0] password_entry_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_oe_hold; sda_oe_o [*8]; endsequence
    sequence s_oe_off; !sda_oe_o [*4]; endsequence
    sequence s_pwe_still; $stable(password_entry_o) [*8]; endsequence
    property p_sda_low; sda_o == 1'b0; endproperty
    property p_reset_vals;
        $rose(reset_n_i) |-> page_select_o == 8'h00 && password_entry_o == 32'hffff_ffff;
    endproperty
    property p_page_range; page_select_o <= PAGE_MAX; endproperty
    property p_page_scl; $changed(page_select_o) |-> !scl_i; endproperty
    property p_oe_quiet; $rose(reset_n_i) |-> s_oe_off; endproperty
    property p_oe_scl; $changed(sda_oe_o) |-> !scl_i; endproperty
    property p_oe_hold; $rose(sda_oe_o) |-> s_oe_hold; endproperty
    property p_pwe_hold; $changed(password_entry_o) |=> s_pwe_still; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda data not low");
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
    a_page_range: assert property (p_page_range) else $error("page out of range");
    a_page_scl: assert property (p_page_scl) else $error("page moved, scl high");
    a_oe_quiet: assert property (p_oe_quiet) else $error("sda pulled at reset");
    a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
    a_oe_hold: assert property (p_oe_hold) else $error("sda pull too short");
    a_pwe_hold: assert property (p_pwe_hold) else $error("password bytes churn");
endmodule : pmm_memory_map_properties

bind pmm_memory_map pmm_memory_map_properties u_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .page_select_o(page_select_o),
    .password_entry_o(password_entry_o));

// ==== dv/pmm_memory_map_test.sv ====
// Self-checking bench for the paged monitor memory map
module pmm_memory_map_test
    import pmm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk_i, reset_n_i, scl_i, pull, sda_o, sda_oe_o, acked;
    logic [1:0]               priv_level_i;
    logic                     power_on_state_i, data_input_i, rate_select_input_i;
    logic                     fault_input_i, loss_input_i;
    logic [2:0]               fast_trip_i;
    logic [NUM_QTY-1:0]       meas_valid_i;
    logic [NUM_QTY-1:0][15:0] meas_value_i, ahi, alo, whi, wlo;
    logic [7:0]               page_select_o, rd_byte;
    logic [31:0]              password_entry_o;
    int                       miscompares, samples_checked, cycles;
    wire logic                sda_i = !(pull | sda_oe_o);
    pmm_host_model host (.scl_o(scl_i), .pull_o(pull), .sda_i(sda_i));
    pmm_memory_map uut (.clk_i, .reset_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .priv_level_i,
        .power_on_state_i, .data_input_i, .rate_select_input_i, .fault_input_i,
        .loss_input_i, .fast_trip_i, .meas_valid_i, .meas_value_i, .alarm_high_limit_i(ahi),
        .alarm_low_limit_i(alo), .warn_high_limit_i(whi), .warn_low_limit_i(wlo),
        .page_select_o, .password_entry_o);
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic end_sim;
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #0.125;
        host.wr(a, d, acked);
        chk({31'h0, acked}, 32'h1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i) #0.125;
        host.rd(a, rd_byte, acked);
        chk({23'h0, acked, rd_byte}, {23'h0, 1'b1, exp});
    endtask : rd
    task automatic lvl(input logic [1:0] p);
        @(posedge clk_i);
        priv_level_i <= p;
    endtask : lvl
    task automatic t_reset;
        chk(password_entry_o, 32'hffff_ffff);
        rd(ADDR_CONV_FRESH, FRESH_RESET);
        wr(ADDR_PWE_0, 8'h5a);
        chk(password_entry_o, 32'hffff_ff5a);
        wr(ADDR_PAGE_SEL, 8'h02);
        chk({24'h0, page_select_o}, 32'h2);
        wr(ADDR_PAGE_SEL, 8'h04);
        rd(ADDR_PAGE_SEL, 8'h02);
    endtask : t_reset
    task automatic t_priv;
        lvl(LEVEL_2);
        wr(8'h90, 8'h33);
        lvl(LEVEL_1);
        wr(8'h90, 8'h44);
        rd(8'h90, 8'h00);
        lvl(LEVEL_2);
        rd(8'h90, 8'h33);
        wr(8'h10, 8'hc3);
        wr(ADDR_PAGE_SEL, 8'h01);
        lvl(LEVEL_1);
        wr(8'h10, 8'h3c);
        rd(8'h10, 8'hc3);
        wr(8'h80, 8'ha5);
        lvl(2'h0);
        wr(8'h80, 8'h5a);
        lvl(LEVEL_1);
        rd(8'h80, 8'ha5);
        wr(ADDR_PAGE_SEL, 8'h00);
        wr(8'h80, 8'h77);
        rd(8'h80, 8'h00);
    endtask : t_priv
    task automatic t_monitor;
        @(posedge clk_i);
        meas_value_i[1] <= 16'h1234;
        meas_valid_i <= 5'h12;
        @(posedge clk_i);
        meas_valid_i <= 5'h00;
        rd(8'h62, 8'h12);
        rd(8'h63, 8'h34);
        rd(ADDR_CONV_FRESH, 8'h48);
        rd(ADDR_ALARM_3, 8'h20);
        rd(8'h71, 8'h40);
        rd(ADDR_ALARM_0, 8'h80);
        rd(ADDR_WARN_3, 8'h00);
        wr(ADDR_CONV_FRESH, 8'h00);
        rd(ADDR_CONV_FRESH, 8'h00);
        wr(ADDR_PIN_STATES, 8'hff);
        rd(ADDR_PIN_STATES, 8'h92);
    endtask : t_monitor
    task automatic t_flags;
        wr(ADDR_ALARM_3, 8'h00);
        rd(ADDR_ALARM_3, 8'h20);
        lvl(LEVEL_2);
        wr(ADDR_PAGE_SEL, 8'h03);
        wr(8'he8, 8'h00);
        wr(ADDR_ALARM_3, 8'h00);
        rd(ADDR_ALARM_3, 8'h20);
        wr(8'he8, 8'h01);
        wr(8'h72, 8'hff);
        rd(8'h72, 8'h0a);
        wr(ADDR_ALARM_3, 8'h00);
        rd(ADDR_ALARM_3, 8'h00);
    endtask : t_flags
    initial begin
        {reset_n_i, priv_level_i, meas_valid_i, meas_value_i} = '0;
        {power_on_state_i, data_input_i, rate_select_input_i} = 3'b011;
        {fault_input_i, loss_input_i, fast_trip_i} = 5'b01100;
        {ahi, alo} = {{NUM_QTY{16'h1000}}, {NUM_QTY{16'h0010}}};
        {whi, wlo} = {{NUM_QTY{16'hffff}}, {NUM_QTY{16'h0000}}};
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        t_reset();
        t_priv();
        t_monitor();
        t_flags();
        end_sim();
    end
endmodule : pmm_memory_map_test

// ==== verilog/pmm_memory_map.sv ====
// Paged monitor memory map with privilege checks and monitor bytes

// Function
// RQ1: Addresses below 80h hit one shared region, 80h to FFh hit the selected upper page.
// RQ2: The page select byte takes only page numbers 00h to 03h.
// RQ3: Page 00h has no storage behind the upper addresses.
// RQ4: Page 01h needs level 1 and pages 02h and 03h need level 2 for upper access.
// RQ5: Identification bytes from 00h are nonvolatile, readable by all, writable at level 2.
// RQ6: Shared bytes 60h to 7Fh are volatile registers.
// RQ7: The input-state byte is read-only, bit 0 the power-on state, upper bits the pins.
// RQ8: The conversion-fresh byte is host read/write and set by the device, bits 7 to 3.
// RQ9: Flag bytes are readable by all, writable at level 2 with the page 03h E8h bit set.
// RQ10: The host leaves reserved locations alone.
// RQ11: All host access goes over the two-wire slave with byte addressing.
// RQ12: Each measurement is two bytes, high byte at the even address.
// RQ13: Each update sets a high flag above the high limit, a low flag below the low limit.
// RQ14: A host write of 00h clears fresh bits, each fresh conversion sets its bit.
// RQ15: Flags sit as high/low pairs from bit 7 of bytes 3 and 2, fast trips in bytes 1 and 0.
// RQ16: Writes lacking privilege are dropped and leave the byte unchanged.
module pmm_memory_map
    import pmm_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    input  wire logic [1:0]                priv_level_i,
    input  wire logic                      power_on_state_i,
    input  wire logic                      data_input_i,
    input  wire logic                      rate_select_input_i,
    input  wire logic                      fault_input_i,
    input  wire logic                      loss_input_i,
    input  wire logic [2:0]                fast_trip_i,
    input  wire logic [NUM_QTY-1:0]        meas_valid_i,
    input  wire logic [NUM_QTY-1:0][15:0]  meas_value_i,
    input  wire logic [NUM_QTY-1:0][15:0]  alarm_high_limit_i,
    input  wire logic [NUM_QTY-1:0][15:0]  alarm_low_limit_i,
    input  wire logic [NUM_QTY-1:0][15:0]  warn_high_limit_i,
    input  wire logic [NUM_QTY-1:0][15:0]  warn_low_limit_i,
    output logic [7:0]                     page_select_o,
    output logic [31:0]                    password_entry_o
);
    logic [7:0]                id_mem [0:ID_BYTES-1];
    logic [7:0]                upper_mem [0:UPPER_BYTES-1];
    logic [NUM_QTY-1:0][15:0]  meas;
    logic [7:0]                fresh;
    logic [31:0]               alarm;
    logic [31:0]               warn;
    logic [7:0]                page_sel;
    logic [31:0]               password_entry;
    logic [6:0]                pin_raw;
    logic [6:0]                pin_meta;
    logic [6:0]                pin_sync;
    logic [7:0]                pin_states;
    logic [7:0]                host_addr;
    logic [7:0]                host_wdata;
    logic                      host_wr;
    logic [7:0]                rd_data;
    logic [7:0]                next_fresh;
    logic [31:0]               next_alarm;
    logic [31:0]               next_warn;
    logic                      flag_cfg_set;
    logic                      flag_wr_ok;
    logic [8:0]                upper_index;

    // Upper page privilege check
    function automatic logic upper_allowed(input logic [1:0] page, input logic [1:0] level);
        logic ok;
        ok = 1'b0;
        if (page == PAGE_NONE) begin
            ok = 1'b0; // RQ3
        end else if (page == PAGE_USER) begin
            ok = (level >= LEVEL_1); // RQ4
        end else begin
            ok = (level >= LEVEL_2); // RQ4
        end
        return ok;
    endfunction : upper_allowed

    // Greater-than limit comparison for high and low flags, temperature is signed
    function automatic logic above(input int q, input logic [15:0] v, input logic [15:0] lim);
        logic r;
        r = 1'b0;
        if (q == 0) begin
            r = $signed(v) > $signed(lim);
        end else begin
            r = v > lim;
        end
        return r;
    endfunction : above

    pmm_twi_slave u_twi (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .sda_o     (sda_o),
        .sda_oe_o  (sda_oe_o),
        .addr_o    (host_addr),
        .rd_data_i (rd_data),
        .wr_o      (host_wr),
        .wr_data_o (host_wdata)
    );

    // Digital input pin synchronisers
    assign pin_raw = {data_input_i, rate_select_input_i, fault_input_i, loss_input_i,
                      fast_trip_i};

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_pin_sync
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    pin_meta[g] <= 1'b0;
                    pin_sync[g] <= 1'b0;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    // Input-state byte, pins and power-on state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pin_states <= 8'h00;
        end else begin
            pin_states <= {pin_sync[6], 2'b00, pin_sync[5], 1'b0, pin_sync[4], pin_sync[3],
                           power_on_state_i}; // RQ7
        end
    end

    assign upper_index  = 9'((page_sel[1:0] - 2'h1) * 128) + 9'(host_addr[6:0]);
    assign flag_cfg_set = upper_mem[256 + int'(ADDR_FLAG_CFG_LOW)][FLAG_CFG_BIT];
    assign flag_wr_ok   = (priv_level_i >= LEVEL_2) && flag_cfg_set; // RQ9

    // Identification bytes, nonvolatile so no reset
    always_ff @(posedge clk_i) begin
        if (host_wr && host_addr < ADDR_VOLATILE_BASE && priv_level_i >= LEVEL_2) begin
            id_mem[host_addr[6:0]] <= host_wdata; // RQ5
        end
    end

    // Upper page storage
    always_ff @(posedge clk_i) begin
        if (host_wr && host_addr >= ADDR_UPPER_BASE
            && upper_allowed(page_sel[1:0], priv_level_i)) begin
            upper_mem[upper_index] <= host_wdata; // RQ1
        end
    end

    // Measurement pairs
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            meas <= '0;
        end else begin
            for (int q = 0; q < NUM_QTY; q++) begin
                if (meas_valid_i[q]) begin
                    meas[q] <= meas_value_i[q]; // RQ12
                end
            end
        end
    end

    // Conversion-fresh byte, device set wins over host clear
    always_comb begin
        next_fresh = fresh;
        if (host_wr && host_addr == ADDR_CONV_FRESH) begin
            next_fresh = host_wdata & FRESH_MASK; // RQ14
        end
        for (int q = 0; q < NUM_QTY; q++) begin
            if (meas_valid_i[q]) begin
                next_fresh[7-q] = 1'b1; // RQ8
            end
        end
    end

    // Alarm and warning flags
    always_comb begin
        next_alarm = alarm;
        next_warn  = warn;
        if (host_wr && flag_wr_ok) begin
            if (host_addr >= ADDR_ALARM_3 && host_addr <= ADDR_ALARM_0) begin
                next_alarm[(3 - int'(host_addr[1:0])) * 8 +: 8] =
                    host_wdata & ALARM_RW_MASK[(3 - int'(host_addr[1:0])) * 8 +: 8];
            end else if (host_addr >= ADDR_WARN_3 && host_addr <= ADDR_WARN_0) begin
                next_warn[(3 - int'(host_addr[1:0])) * 8 +: 8] =
                    host_wdata & WARN_RW_MASK[(3 - int'(host_addr[1:0])) * 8 +: 8];
            end
        end
        for (int q = 0; q < NUM_QTY; q++) begin
            if (meas_valid_i[q]) begin
                next_alarm[31-2*q] = above(q, meas_value_i[q], alarm_high_limit_i[q]); // RQ13
                next_alarm[30-2*q] = above(q, alarm_low_limit_i[q], meas_value_i[q]); // RQ13
                next_warn[31-2*q]  = above(q, meas_value_i[q], warn_high_limit_i[q]); // RQ15
                next_warn[30-2*q]  = above(q, warn_low_limit_i[q], meas_value_i[q]); // RQ15
            end
        end
        if (meas_valid_i[2]) begin
            next_alarm[BIT_FT_BIAS] = pin_sync[0]; // RQ15
        end
        if (meas_valid_i[3]) begin
            next_alarm[BIT_FT_POWER] = pin_sync[1]; // RQ15
        end
        if (meas_valid_i[4]) begin
            next_alarm[BIT_FT_RX] = pin_sync[2]; // RQ15
        end
    end

    // Volatile status registers
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            fresh <= FRESH_RESET;
            alarm <= FLAG_RESET; // RQ6
            warn  <= FLAG_RESET;
        end else begin
            fresh <= next_fresh;
            alarm <= next_alarm;
            warn  <= next_warn; // RQ16
        end
    end

    // Password entry and page select
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            password_entry <= {4{PWE_RESET}};
            page_sel       <= PAGE_SEL_RESET;
        end else if (host_wr) begin
            if (host_addr >= ADDR_PWE_3 && host_addr <= ADDR_PWE_0) begin
                password_entry[(int'(ADDR_PWE_0 - host_addr)) * 8 +: 8] <= host_wdata;
            end else if (host_addr == ADDR_PAGE_SEL && host_wdata <= PAGE_MAX) begin
                page_sel <= host_wdata; // RQ2
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            page_select_o    <= PAGE_SEL_RESET;
            password_entry_o <= {4{PWE_RESET}};
        end else begin
            page_select_o    <= page_sel;
            password_entry_o <= password_entry;
        end
    end

    // Read decode
    always_comb begin
        rd_data = 8'h00;
        if (host_addr >= ADDR_UPPER_BASE) begin
            if (upper_allowed(page_sel[1:0], priv_level_i)) begin
                rd_data = upper_mem[upper_index]; // RQ4
            end
        end else if (host_addr < ADDR_VOLATILE_BASE) begin
            rd_data = id_mem[host_addr[6:0]]; // RQ5
        end else if (host_addr <= ADDR_MEAS_LAST) begin
            if (host_addr[0] == 1'b0) begin
                rd_data = meas[int'((host_addr - ADDR_MEAS_BASE) >> 1)][15:8]; // RQ12
            end else begin
                rd_data = meas[int'((host_addr - ADDR_MEAS_BASE) >> 1)][7:0];
            end
        end else if (host_addr == ADDR_PIN_STATES) begin
            rd_data = pin_states; // RQ7
        end else if (host_addr == ADDR_CONV_FRESH) begin
            rd_data = fresh; // RQ8
        end else if (host_addr >= ADDR_ALARM_3 && host_addr <= ADDR_ALARM_0) begin
            rd_data = alarm[(3 - int'(host_addr[1:0])) * 8 +: 8]; // RQ9
        end else if (host_addr >= ADDR_WARN_3 && host_addr <= ADDR_WARN_0) begin
            rd_data = warn[(3 - int'(host_addr[1:0])) * 8 +: 8];
        end else if (host_addr >= ADDR_PWE_3 && host_addr <= ADDR_PWE_0) begin
            rd_data = password_entry[(int'(ADDR_PWE_0 - host_addr)) * 8 +: 8];
        end else if (host_addr == ADDR_PAGE_SEL) begin
            rd_data = page_sel; // RQ1
        end
    end
endmodule : pmm_memory_map

// ==== verilog/pmm_pkg.sv ====
// Constants for the paged monitor memory map
package pmm_pkg;
    localparam logic [6:0]  PMM_DEV_ADDR       = 7'h51; // Arbitrary bus address value
    localparam logic [7:0]  ADDR_MEAS_BASE     = 8'h60;
    localparam logic [7:0]  ADDR_MEAS_LAST     = 8'h69;
    localparam logic [7:0]  ADDR_PIN_STATES    = 8'h6e;
    localparam logic [7:0]  ADDR_CONV_FRESH    = 8'h6f;
    localparam logic [7:0]  ADDR_ALARM_3       = 8'h70;
    localparam logic [7:0]  ADDR_ALARM_0       = 8'h73;
    localparam logic [7:0]  ADDR_WARN_3        = 8'h74;
    localparam logic [7:0]  ADDR_WARN_0        = 8'h77;
    localparam logic [7:0]  ADDR_PWE_3         = 8'h7b;
    localparam logic [7:0]  ADDR_PWE_0         = 8'h7e;
    localparam logic [7:0]  ADDR_PAGE_SEL      = 8'h7f;
    localparam logic [7:0]  ADDR_VOLATILE_BASE = 8'h60;
    localparam logic [7:0]  ADDR_UPPER_BASE    = 8'h80;
    localparam logic [7:0]  PAGE_MAX           = 8'h03;
    localparam logic [1:0]  PAGE_NONE          = 2'h0;
    localparam logic [1:0]  PAGE_USER          = 2'h1;
    localparam logic [1:0]  PAGE_FLAG_CFG      = 2'h3;
    localparam logic [6:0]  ADDR_FLAG_CFG_LOW  = 7'h68;   // E8h inside the page
    localparam int          FLAG_CFG_BIT       = 0;
    localparam logic [1:0]  LEVEL_1            = 2'h1;
    localparam logic [1:0]  LEVEL_2            = 2'h2;
    localparam logic [7:0]  PWE_RESET          = 8'hff;
    localparam logic [7:0]  PAGE_SEL_RESET     = 8'h00;
    localparam logic [7:0]  FRESH_RESET        = 8'h00;
    localparam logic [7:0]  FRESH_MASK         = 8'hf8;
    localparam logic [31:0] FLAG_RESET         = 32'h0000_0000;
    localparam logic [31:0] ALARM_RW_MASK      = 32'hffc0_0a80;
    localparam logic [31:0] WARN_RW_MASK       = 32'hffc0_0000;
    localparam int          NUM_QTY            = 5;
    localparam int          ID_BYTES           = 96;
    localparam int          UPPER_BYTES        = 384;
    localparam int          BIT_FT_BIAS        = 11;
    localparam int          BIT_FT_POWER       = 9;
    localparam int          BIT_FT_RX          = 7;
    localparam logic [3:0]  BITS_PER_BYTE      = 4'd8;
endpackage : pmm_pkg

// ==== verilog/pmm_twi_slave.sv ====
// Two-wire serial slave byte engine with address pointer
module pmm_twi_slave
    import pmm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [7:0]      addr_o,
    input  wire logic [7:0] rd_data_i,
    output logic            wr_o,
    output logic [7:0]      wr_data_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} pmm_tw_state_t;
    typedef enum logic [1:0] {RL_DEV, RL_WORD, RL_DATA} pmm_tw_role_t;

    pmm_tw_state_t state;
    pmm_tw_role_t  role;
    logic [2:0]    scl_sync;
    logic [2:0]    sda_sync;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic          read_mode;
    logic          master_ack;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_cond;
    logic          stop_cond;

    // Pin synchronisers, stage 0 feeds stage 1 only
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
        end
    end

    assign scl_rise   = scl_sync[1] & ~scl_sync[2];
    assign scl_fall   = ~scl_sync[1] & scl_sync[2];
    assign start_cond = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
    assign stop_cond  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

    // Byte protocol engine
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state      <= ST_IDLE;
            role       <= RL_DEV;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            read_mode  <= 1'b0;
            master_ack <= 1'b0;
            sda_o      <= 1'b0;
            sda_oe_o   <= 1'b0;
            addr_o     <= 8'h00;
            wr_o       <= 1'b0;
            wr_data_o  <= 8'h00;
        end else begin
            wr_o <= 1'b0;
            if (start_cond) begin
                state    <= ST_RX;
                role     <= RL_DEV;
                bit_cnt  <= 4'h0;
                sda_oe_o <= 1'b0;
            end else if (stop_cond) begin
                state    <= ST_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shreg   <= {shreg[6:0], sda_sync[1]};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                            state    <= ST_ACK;
                            sda_oe_o <= 1'b1;
                            if (role == RL_DEV) begin
                                if (shreg[7:1] == PMM_DEV_ADDR) begin
                                    read_mode <= shreg[0];
                                end else begin
                                    state    <= ST_IDLE;
                                    sda_oe_o <= 1'b0;
                                end
                            end else if (role == RL_WORD) begin
                                addr_o <= shreg; // RQ11
                            end else begin
                                wr_o      <= 1'b1; // RQ11
                                wr_data_o <= shreg;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (role == RL_DEV && read_mode) begin
                                state    <= ST_TX;
                                shreg    <= rd_data_i;
                                sda_oe_o <= ~rd_data_i[7];
                            end else begin
                                state    <= ST_RX;
                                sda_oe_o <= 1'b0;
                                if (role == RL_DEV) begin
                                    role <= RL_WORD;
                                end else begin
                                    role <= RL_DATA;
                                end
                                if (role == RL_DATA) begin
                                    addr_o <= addr_o + 8'h01;
                                end
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt == BITS_PER_BYTE) begin
                                state    <= ST_MACK;
                                sda_oe_o <= 1'b0;
                                addr_o   <= addr_o + 8'h01;
                            end else begin
                                shreg    <= {shreg[6:0], 1'b0};
                                sda_oe_o <= ~shreg[6];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_sync[1];
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (master_ack) begin
                                state    <= ST_TX;
                                shreg    <= rd_data_i;
                                sda_oe_o <= ~rd_data_i[7];
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule : pmm_twi_slave
